// *** include/dsp_defs.vh ***
// register addresses, field positions and reset values of the host port
`ifndef DSP_DEFS_VH
`define DSP_DEFS_VH
// serial channel register addresses
`define DSP_ADDR_IER        3'h1
`define DSP_ADDR_IIR        3'h2
`define DSP_ADDR_MCR        3'h4
`define DSP_ADDR_MSR        3'h6
// printer port register addresses
`define DSP_ADDR_PSTAT      3'h1
`define DSP_ADDR_PCTRL      3'h2
// modem status field positions
`define DSP_MSR_DCTS        0
`define DSP_MSR_DDSR        1
`define DSP_MSR_DDCD        3
`define DSP_MSR_CTS         4
`define DSP_MSR_DSR         5
`define DSP_MSR_DCD         7
// modem control field positions
`define DSP_MCR_DTR         0
`define DSP_MCR_IRQ_EN      3
// interrupt enable field positions
`define DSP_IER_RDA         0
`define DSP_IER_THRE        1
`define DSP_IER_RLS         2
`define DSP_IER_MS          3
// printer control and status fields
`define DSP_PCTRL_INIT      2
`define DSP_PCTRL_IRQ_EN    4
`define DSP_PSTAT_PIRQ      2
`define DSP_PSTAT_ERR       3
// reset values
`define DSP_MCR_RST         8'h00
`define DSP_IER_RST         8'h00
`define DSP_PCTRL_RST       8'h04
`endif

// *** design/dsp_sync2.v ***
// two-flop synchroniser for one asynchronous level
module dsp_sync2 (
  input  wire clk,
  input  wire sys_rst,
  input  wire din,
  output reg  dout
);
  reg stage1;

  // first stage feeds only the second; both reset to the idle high
  // of a low-active line, so no false rising edge follows reset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// *** design/dsp_modem_chan.v ***
// one serial channel: modem status, modem control, interrupt enable
`include "dsp_defs.vh"
module dsp_modem_chan (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       wr_pulse,
  input  wire       rd_pulse,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       cts_n,
  input  wire       dsr_n,
  input  wire       dcd_n,
  input  wire       rx_error,
  input  wire       rx_data_avail,
  input  wire       thr_empty,
  output reg  [7:0] rdata,
  output wire       dtr_n,
  output wire       irq,
  output wire       irq_oe
);
  reg  [7:0] modem_control_reg;
  reg  [7:0] ier;
  reg  [2:0] prev_lvl;
  reg  [2:0] delta;
  wire [2:0] lvl;
  wire [2:0] chg;
  wire [7:0] modem_status_reg;
  wire       ms_pending;
  wire       msr_rd;

  // pins are active low; the status shows the asserted sense
  assign lvl = {~dcd_n, ~dsr_n, ~cts_n};
  assign chg = lvl ^ prev_lvl;
  assign msr_rd = rd_pulse && (addr == `DSP_ADDR_MSR);

  // live levels and change flags; carrier never touches receive logic
  assign modem_status_reg = {lvl[2], 1'b0, lvl[1], lvl[0],
                             delta[2], 1'b0, delta[1], delta[0]};

  // change flags: a change in the read cycle survives the clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_lvl <= 3'h0;
      delta    <= 3'h0;
    end else begin
      prev_lvl <= lvl;
      if (msr_rd)
        delta <= chg;
      else
        delta <= delta | chg;
    end
  end

  // host writes to control and enable registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modem_control_reg <= `DSP_MCR_RST;
      ier               <= `DSP_IER_RST;
    end else if (wr_pulse) begin
      if (addr == `DSP_ADDR_MCR)
        modem_control_reg <= wdata;
      if (addr == `DSP_ADDR_IER)
        ier <= wdata;
    end
  end

  // read mux, bit 0 of the value on bus bit 0
  always @* begin
    case (addr)
      `DSP_ADDR_IER: rdata = ier;
      `DSP_ADDR_IIR: rdata = {7'h00, ~irq};
      `DSP_ADDR_MCR: rdata = modem_control_reg;
      `DSP_ADDR_MSR: rdata = modem_status_reg;
      default:       rdata = 8'h00;
    endcase
  end

  assign dtr_n = ~modem_control_reg[`DSP_MCR_DTR];
  assign ms_pending = |delta;
  // interrupt level clears itself once its source is serviced
  assign irq = (ier[`DSP_IER_RLS]  & rx_error) |
               (ier[`DSP_IER_RDA]  & rx_data_avail) |
               (ier[`DSP_IER_THRE] & thr_empty) |
               (ier[`DSP_IER_MS]   & ms_pending);
  assign irq_oe = modem_control_reg[`DSP_MCR_IRQ_EN];
endmodule

// *** design/dsp_host_port.v ***
// host front end: strobe decode, two modem channels, printer interrupt
// Function
// - channel status bit 4 shows the clear-to-send level.
// - status bit 0 flags clear-to-send change since last status read.
// - carrier level in bit 7, change in bit 3; no receiver effect.
// - data-set-ready level in bit 5, change flag in bit 1.
// - terminal-ready output low while control bit 0 set, high at reset.
// - data bus is driven only during a host read.
// - bus bit 0 carries each register's least significant bit.
// - mode input low: printer interrupt follows acknowledge directly.
// - mode high: interrupt latches on acknowledge rise, cleared by status read.
// - channel interrupt pin driven only while control bit 3 set.
// - channel interrupt high while any enabled source is active.
// - channel interrupt pins float after reset until enabled.
// - printer interrupt active high, driven only when control bit 4 set.
// - read strobe plus chip select and address puts register on bus.
// - write strobe loads bus data into the addressed register.
// - device drives open-drain initialize line low to start printer init.
// - reset clears modem control and its outputs, idling serial activity.
`include "dsp_defs.vh"
module dsp_host_port (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       host_read_strobe_n,
  input  wire       host_write_strobe_n,
  input  wire       select_serial_one_n,
  input  wire       select_serial_two_n,
  input  wire       select_printer_n,
  input  wire [2:0] addr,
  input  wire [7:0] host_data_bus_in,
  output reg  [7:0] host_data_bus_out,
  output wire       host_data_bus_oe,
  input  wire       cts1_n,
  input  wire       dsr1_n,
  input  wire       dcd1_n,
  input  wire       cts2_n,
  input  wire       dsr2_n,
  input  wire       dcd2_n,
  output wire       dtr1_n,
  output wire       dtr2_n,
  input  wire [1:0] rx_error,
  input  wire [1:0] rx_data_avail,
  input  wire [1:0] thr_empty,
  output wire       serial_irq_ch1,
  output wire       serial_irq_ch1_oe,
  output wire       serial_irq_ch2,
  output wire       serial_irq_ch2_oe,
  input  wire       printer_irq_mode_select,
  input  wire       printer_ack_n,
  input  wire       printer_err_n,
  input  wire       printer_init_in,
  output wire       printer_init_out,
  output wire       printer_init_oe,
  output wire       printer_irq_out,
  output wire       printer_irq_out_oe
);
  reg        rd_q;
  reg        wr_q;
  reg        ack_q;
  reg        pirq_latch;
  reg  [7:0] pctrl;
  reg  [7:0] next_bus;
  wire       rd_act;
  wire       wr_act;
  wire       rd_pulse;
  wire       wr_pulse;
  wire       wr1;
  wire       wr2;
  wire       rd1;
  wire       rd2;
  wire       ack_s;
  wire       ack_rise;
  wire       pstat_rd;
  wire [7:0] rdata1;
  wire [7:0] rdata2;
  wire [7:0] pstat;

  ////////////////////////////////////////////////////////////////////////
  // strobe edge detection; strobes treated as synchronous inputs
  assign rd_act = ~host_read_strobe_n;
  assign wr_act = ~host_write_strobe_n;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end

  // one action per strobe; a long strobe must not clear flags twice
  assign rd_pulse = rd_act & ~rd_q;
  // write takes data at the strobe's trailing edge, when bus is settled
  assign wr_pulse = ~wr_act & wr_q;

  assign wr1 = wr_pulse & ~select_serial_one_n;
  assign wr2 = wr_pulse & ~select_serial_two_n;
  assign rd1 = rd_pulse & ~select_serial_one_n;
  assign rd2 = rd_pulse & ~select_serial_two_n;

  ////////////////////////////////////////////////////////////////////////
  // serial channels
  dsp_modem_chan u_chan1 (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .wr_pulse      (wr1),
    .rd_pulse      (rd1),
    .addr          (addr),
    .wdata         (host_data_bus_in),
    .cts_n         (cts1_n),
    .dsr_n         (dsr1_n),
    .dcd_n         (dcd1_n),
    .rx_error      (rx_error[0]),
    .rx_data_avail (rx_data_avail[0]),
    .thr_empty     (thr_empty[0]),
    .rdata         (rdata1),
    .dtr_n         (dtr1_n),
    .irq           (serial_irq_ch1),
    .irq_oe        (serial_irq_ch1_oe)
  );

  dsp_modem_chan u_chan2 (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .wr_pulse      (wr2),
    .rd_pulse      (rd2),
    .addr          (addr),
    .wdata         (host_data_bus_in),
    .cts_n         (cts2_n),
    .dsr_n         (dsr2_n),
    .dcd_n         (dcd2_n),
    .rx_error      (rx_error[1]),
    .rx_data_avail (rx_data_avail[1]),
    .thr_empty     (thr_empty[1]),
    .rdata         (rdata2),
    .dtr_n         (dtr2_n),
    .irq           (serial_irq_ch2),
    .irq_oe        (serial_irq_ch2_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // printer port control register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      pctrl <= `DSP_PCTRL_RST;
    else if (wr_pulse && ~select_printer_n && addr == `DSP_ADDR_PCTRL)
      pctrl <= host_data_bus_in;
  end

  // acknowledge passes a synchroniser before any edge logic
  dsp_sync2 u_ack_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (printer_ack_n),
    .dout    (ack_s)
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ack_q <= 1'b1; // idle level, matches the synchroniser reset
    else
      ack_q <= ack_s;
  end

  assign ack_rise = ack_s & ~ack_q;
  assign pstat_rd = rd_pulse && ~select_printer_n &&
                    addr == `DSP_ADDR_PSTAT;

  // latched interrupt; a rise coincident with the clearing read wins
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      pirq_latch <= 1'b0;
    else if (ack_rise)
      pirq_latch <= 1'b1;
    else if (pstat_rd)
      pirq_latch <= 1'b0;
  end

  // status bit is the inverse of the latched interrupt
  assign pstat = {4'h0, printer_err_n, ~pirq_latch, 2'h0};

  // direct mode follows the synchronised acknowledge
  assign printer_irq_out = printer_irq_mode_select ? pirq_latch
                                                   : ack_s;
  assign printer_irq_out_oe = pctrl[`DSP_PCTRL_IRQ_EN];

  // open drain: only ever pull low; control bit clear asserts init
  assign printer_init_out = 1'b0;
  assign printer_init_oe  = ~pctrl[`DSP_PCTRL_INIT];

  ////////////////////////////////////////////////////////////////////////
  // read data path, registered so the bus value is glitch free
  always @* begin
    if (~select_serial_one_n)
      next_bus = rdata1;
    else if (~select_serial_two_n)
      next_bus = rdata2;
    else if (~select_printer_n) begin
      case (addr)
        `DSP_ADDR_PSTAT: next_bus = pstat;
        `DSP_ADDR_PCTRL: next_bus = {3'h0, pctrl[4:0]};
        3'h3:            next_bus = {7'h00, printer_init_in};
        default:         next_bus = 8'h00;
      endcase
    end else
      next_bus = 8'h00;
  end

  // data captured at the read strobe's first edge, before flags clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      host_data_bus_out <= 8'h00;
    else if (rd_pulse)
      host_data_bus_out <= next_bus;
  end

  // driven only while a selected read is in progress
  assign host_data_bus_oe = rd_act & rd_q &
    ~(select_serial_one_n & select_serial_two_n & select_printer_n);
endmodule

// *** tb/dsp_host_port_asserts.sv ***
// assertions on the host port pins
`include "dsp_defs.vh"
module dsp_host_port_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire       host_read_strobe_n,
  input wire       host_write_strobe_n,
  input wire       select_serial_one_n,
  input wire       select_printer_n,
  input wire [2:0] addr,
  input wire [7:0] host_data_bus_in,
  input wire       host_data_bus_oe,
  input wire       dtr1_n,
  input wire       serial_irq_ch1_oe,
  input wire       printer_irq_mode_select,
  input wire       printer_ack_n,
  input wire       printer_init_out,
  input wire       printer_init_oe,
  input wire       printer_irq_out,
  input wire       printer_irq_out_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] age;
  // the synchroniser shows reset values for its first edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  // steps: read taken, write taken, acknowledge release
  sequence s_rd_take;
    $fell(host_read_strobe_n) && !(select_serial_one_n && select_printer_n);
  endsequence
  sequence s_wr_take;
    $rose(host_write_strobe_n);
  endsequence
  sequence s_ack_rise;
    $rose(printer_ack_n) && printer_irq_mode_select;
  endsequence
  ////////////////////////////////////////////////////////////
  chk_bus_idle: assert property (
    host_read_strobe_n |-> !host_data_bus_oe) else $error("bus driven idle");
  chk_read_drive: assert property (
    s_rd_take ##1 !host_read_strobe_n |-> host_data_bus_oe)
    else $error("bus not driven in read");
  chk_reset_idle: assert property (
    $fell(sys_rst) |-> dtr1_n && !serial_irq_ch1_oe && !printer_irq_out_oe
      && !printer_init_oe) else $error("outputs not idle after reset");
  chk_mcr_load: assert property (
    s_wr_take ##0 (!select_serial_one_n && addr == `DSP_ADDR_MCR) |=>
      dtr1_n == !$past(host_data_bus_in[0]) &&
      serial_irq_ch1_oe == $past(host_data_bus_in[3]))
    else $error("modem control write lost");
  chk_pctrl_load: assert property (
    s_wr_take ##0 (!select_printer_n && addr == `DSP_ADDR_PCTRL) |=>
      printer_irq_out_oe == $past(host_data_bus_in[4]) &&
      printer_init_oe == !$past(host_data_bus_in[2]))
    else $error("printer control write lost");
  chk_init_low: assert property (
    printer_init_oe |-> !printer_init_out) else $error("init not pulled low");
  chk_direct_follow: assert property (
    age == 2'h3 && !printer_irq_mode_select |->
      printer_irq_out == $past(printer_ack_n, 2))
    else $error("direct interrupt wrong");
  chk_latch_set: assert property (
    s_ack_rise |-> ##[2:3] printer_irq_out) else $error("latch not set");
  chk_latch_hold: assert property (
    printer_irq_mode_select && $past(printer_irq_mode_select) &&
      $past(printer_irq_out) && $past(host_read_strobe_n) |-> printer_irq_out)
    else $error("latch dropped early");
endmodule
bind dsp_host_port dsp_host_port_chk chk_u (.*);

// *** tb/dsp_host_model.sv ***
// host processor model driving the strobe bus
module dsp_host_model (
  input  logic       clk,
  input  logic [7:0] din,
  output logic       rd_n,
  output logic       wr_n,
  output logic [2:0] sel_n,
  output logic [2:0] addr,
  output logic [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel_n = 3'h7;
    addr = 3'h0;
    dout = 8'h00;
  end
  // strobe low two cycles; selects held one cycle past its release
  task automatic xfer(input logic w, input logic [1:0] cs,
                      input logic [2:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(negedge clk);
    sel_n = ~(3'h1 << cs);
    addr = a;
    dout = wd;
    rd_n = w;
    wr_n = !w;
    repeat (2) @(negedge clk);
    rd = din;
    rd_n = 1'b1; // a write lands on this rising strobe
    wr_n = 1'b1;
    @(negedge clk);
    sel_n = 3'h7;
    dout = ~wd; // released lines never keep the last byte
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the host port front end
`include "dsp_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, sys_rst, printer_irq_mode_select, printer_ack_n;
  logic       printer_err_n, cts1_n, dsr1_n, dcd1_n, cts2_n, dsr2_n, dcd2_n;
  logic [1:0] rx_error, rx_data_avail, thr_empty, cs;
  logic [7:0] rdv, ex;
  wire        host_read_strobe_n, host_write_strobe_n, host_data_bus_oe;
  wire        select_serial_one_n, select_serial_two_n, select_printer_n;
  wire        dtr1_n, dtr2_n, serial_irq_ch1, serial_irq_ch1_oe;
  wire        serial_irq_ch2, serial_irq_ch2_oe, printer_init_out;
  wire        printer_init_oe, printer_irq_out, printer_irq_out_oe;
  wire  [2:0] addr, sel_n;
  wire  [7:0] host_data_bus_in, host_data_bus_out;
  int         num_errors, check_count, cycles;
  // rows: {channel, dcd_n dsr_n cts_n, first status read}
  logic [11:0] rows [5] = '{12'h611, 12'h432, 12'h38B, 12'hA99, 12'hF09};
  wire  [7:0] pin_v = {2'h0, dtr1_n, dtr2_n, serial_irq_ch1_oe,
    serial_irq_ch2_oe, printer_irq_out_oe, printer_init_oe | host_data_bus_oe};
  wire        printer_init_in = ~(printer_init_oe & ~printer_init_out);
  assign {select_printer_n, select_serial_two_n, select_serial_one_n} = sel_n;
  dsp_host_port dut_u (.*);
  dsp_host_model host_u (.clk(clk), .din(host_data_bus_out),
    .rd_n(host_read_strobe_n), .wr_n(host_write_strobe_n), .sel_n(sel_n),
    .addr(addr), .dout(host_data_bus_in));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard: the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd_reg(input logic [1:0] c, input logic [2:0] a,
                        input logic [7:0] e);
    host_u.xfer(1'b0, c, a, 8'h00, rdv);
    check(rdv, e);
  endtask
  task automatic wr_reg(input logic [1:0] c, input logic [2:0] a,
                        input logic [7:0] d);
    host_u.xfer(1'b1, c, a, d, rdv);
  endtask
  task automatic do_reset(input int n);
    sys_rst = 1'b1;
    repeat (n) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    check(pin_v, 8'h30);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    printer_irq_mode_select = 1'b0;
    printer_ack_n = 1'b1;
    printer_err_n = 1'b1;
    {cts1_n, dsr1_n, dcd1_n, cts2_n, dsr2_n, dcd2_n} = 6'h3F;
    rx_error = 2'h0;
    rx_data_avail = 2'h0;
    thr_empty = 2'h0;
    do_reset(2);
    $display("test reset done");
    // flush change flags, then the status rows
    host_u.xfer(1'b0, 2'h0, `DSP_ADDR_MSR, 8'h00, rdv);
    host_u.xfer(1'b0, 2'h1, `DSP_ADDR_MSR, 8'h00, rdv);
    foreach (rows[k]) begin
      if (rows[k][11]) {dcd2_n, dsr2_n, cts2_n} = rows[k][10:8];
      else {dcd1_n, dsr1_n, cts1_n} = rows[k][10:8];
      repeat (4) @(negedge clk);
      cs = {1'b0, rows[k][11]};
      ex = rows[k][7:0];
      rd_reg(cs, `DSP_ADDR_MSR, ex);
      rd_reg(cs, `DSP_ADDR_MSR, ex & 8'hB0);
    end
    $display("test status rows done");
    // control writes, read-back, an unmapped place
    wr_reg(2'h0, `DSP_ADDR_MCR, 8'h09);
    wr_reg(2'h1, `DSP_ADDR_MCR, 8'h01);
    check(pin_v, 8'h08);
    rd_reg(2'h0, `DSP_ADDR_MCR, 8'h09);
    rd_reg(2'h0, 3'h7, 8'h00);
    // sources against enables: transmit empty is masked on both
    wr_reg(2'h0, `DSP_ADDR_IER, 8'h01);
    wr_reg(2'h1, `DSP_ADDR_IER, 8'h04);
    thr_empty = 2'h3;
    rx_data_avail = 2'h1;
    rx_error = 2'h2;
    @(negedge clk);
    check({6'h0, serial_irq_ch2, serial_irq_ch1}, 8'h03);
    rx_data_avail = 2'h0;
    rx_error = 2'h0;
    @(negedge clk);
    check({6'h0, serial_irq_ch2, serial_irq_ch1}, 8'h00);
    // modem status change as an interrupt source, serviced by a read
    wr_reg(2'h0, `DSP_ADDR_IER, 8'h08);
    cts1_n = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h0, serial_irq_ch1}, 8'h01);
    rd_reg(2'h0, `DSP_ADDR_MSR, 8'h91);
    check({7'h0, serial_irq_ch1}, 8'h00);
    rd_reg(2'h0, `DSP_ADDR_IIR, 8'h01);
    $display("test serial done");
    // printer: init line, direct then latched interrupt
    wr_reg(2'h2, `DSP_ADDR_PCTRL, 8'h10);
    check({6'h0, printer_init_in, printer_irq_out_oe}, 8'h01);
    wr_reg(2'h2, `DSP_ADDR_PCTRL, 8'h14);
    printer_ack_n = 1'b0;
    repeat (3) @(negedge clk);
    check({6'h0, printer_init_in, printer_irq_out}, 8'h02);
    printer_ack_n = 1'b1;
    repeat (3) @(negedge clk);
    printer_irq_mode_select = 1'b1;
    host_u.xfer(1'b0, 2'h2, `DSP_ADDR_PSTAT, 8'h00, rdv);
    check({7'h0, printer_irq_out}, 8'h00);
    printer_ack_n = 1'b0;
    repeat (3) @(negedge clk);
    printer_ack_n = 1'b1;
    printer_err_n = 1'b0;
    repeat (4) @(negedge clk);
    check({7'h0, printer_irq_out}, 8'h01);
    host_u.xfer(1'b0, 2'h2, `DSP_ADDR_PSTAT, 8'h00, rdv);
    check(rdv & 8'h0C, 8'h00);
    check({7'h0, printer_irq_out}, 8'h00);
    printer_err_n = 1'b1;
    repeat (3) @(negedge clk);
    host_u.xfer(1'b0, 2'h2, `DSP_ADDR_PSTAT, 8'h00, rdv);
    check(rdv & 8'h0C, 8'h0C);
    $display("test printer done");
    do_reset(1);
    // latched mode still selected: reset must not fake an acknowledge edge
    repeat (4) @(negedge clk);
    check({7'h0, printer_irq_out}, 8'h00);
    host_u.xfer(1'b0, 2'h2, `DSP_ADDR_PSTAT, 8'h00, rdv);
    check(rdv & 8'h0C, 8'h0C);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
